/* File: rtl/gpt_timer.sv */
/*
 * gpt_timer: one general purpose timer with apb register access,
 * 54-bit up/down counter, snapshot, match alarm, preset reload and
 * slow clock measurement against the crystal clock.
 * assumes clk is the bus clock; crystal and slow clocks arrive as pins
 * well below half the clk rate.
 */
// Decided for this implementation: the APB interface to the registers and the register addresses.
//
// Function
// RULE1: source is bus clock or crystal clock
// RULE2: prescaler divides by divisor field 2..65536
// RULE3: divisor 0 means 65536, 1 means 2
// RULE4: software stops counter before changing divisor
// RULE5: counter steps per tick when enabled, holds otherwise
// RULE6: direction change applies on the next tick
// RULE7: trigger write latches whole count into snapshots
// RULE8: alarm when count equals 54-bit match value
// RULE9: no alarm unless match is armed
// RULE10: counting up, late arm alarms at once
// RULE11: counting up, otherwise wait for equality
// RULE12: counting down, late arm alarms at once
// RULE13: counting down, otherwise wait for equality
// RULE14: alarm clears arm bit by hardware
// RULE15: alarm raises interrupt, optionally reloads counter
// RULE16: preset registers store only, counter untouched
// RULE17: preset trigger write loads counter at once
// RULE18: after reload, counting resumes or holds
// RULE19: no auto reload means counting past match
// RULE20: slow clock measurement one-shot or periodic
// RULE21: both counters start and stop together
// RULE22: counter wraps modulo two to the 54
// RULE23: interrupt is a level held until cleared
// RULE24: raw bit cleared by write one, status masked
//
`timescale 1ns/10ps
module gpt_timer import gpt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock pins
	input wire logic crystal_clock,
	input wire logic low_speed_clock,
	// interrupt
	output logic timer_irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	logic en_q;
	logic up_q;
	logic reload_q;
	logic arm_q;
	logic xtal_q;
	logic [DIV_W-1:0] div_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] snap_q;
	logic [CNT_W-1:0] match_q;
	logic [CNT_W-1:0] preset_q;
	logic raw_q;
	logic ena_q;
	logic cal_run_q;
	logic cal_cyc_q;
	logic cal_rdy_q;
	logic [TGT_W-1:0] tgt_q;
	logic [TGT_W-1:0] scnt_q;
	logic [DATA_W-1:0] xcnt_q;
	logic [DATA_W-1:0] result_q;

	logic xtal_rise;
	logic slow_rise;
	logic access;
	logic wr;
	logic setup;
	logic mapped;
	logic [DATA_W-1:0] rd_d;
	logic [CNT_W-1:0] diff;
	logic fire;
	logic tick;
	logic cal_start;
	logic cal_done;
	logic [DATA_W-1:0] xcnt_next;

	gpt_tick_if tk ();

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and prescaler
	// a crystal-sourced tick lags its pin edge by four to five clk

	gpt_pin_sync u_xtal_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(crystal_clock),
		.rise(xtal_rise)
	);

	gpt_pin_sync u_slow_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(low_speed_clock),
		.rise(slow_rise)
	);

	// bus clock counts every cycle, crystal only on its rising edges
	assign tk.src_pulse = xtal_q ? xtal_rise : 1'b1; // RULE1
	assign tk.run = en_q;
	assign tk.divisor = div_q; // RULE4

	gpt_prescaler u_pre (
		.clk(clk),
		.sys_rst(sys_rst),
		.tk(tk)
	);

	// a tick still in flight when the timer stops is dropped
	assign tick = tk.tick && en_q; // RULE5

	////////////////////////////////////////////////////////////////////////
	// apb decode

	// read-only offsets swallow writes; only unmapped offsets raise pslverr
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr = access && pwrite;

	always_comb begin
		mapped = 1'b1;
		rd_d = '0;
		unique case (paddr)
			OFS_CONFIG: begin
				rd_d[CFG_EN_BIT] = en_q;
				rd_d[CFG_UP_BIT] = up_q;
				rd_d[CFG_RELOAD_BIT] = reload_q;
				rd_d[CFG_DIV_LSB +: DIV_W] = div_q;
				rd_d[CFG_ARM_BIT] = arm_q;
				rd_d[CFG_XTAL_BIT] = xtal_q;
			end
			OFS_SNAP_LO: rd_d = snap_q[LO_W-1:0];
			OFS_SNAP_HI: rd_d[HI_W-1:0] = snap_q[CNT_W-1:LO_W];
			OFS_SNAP_TRIG: rd_d = '0;
			OFS_MATCH_LO: rd_d = match_q[LO_W-1:0];
			OFS_MATCH_HI: rd_d[HI_W-1:0] = match_q[CNT_W-1:LO_W];
			OFS_PRESET_LO: rd_d = preset_q[LO_W-1:0];
			OFS_PRESET_HI: rd_d[HI_W-1:0] = preset_q[CNT_W-1:LO_W];
			OFS_PRESET_TRIG: rd_d = '0;
			OFS_INT_ENA: rd_d[0] = ena_q;
			OFS_INT_RAW: rd_d[0] = raw_q;
			OFS_INT_ST: rd_d[0] = raw_q && ena_q; // RULE24
			OFS_INT_CLR: rd_d = '0;
			OFS_CAL_CFG: begin
				rd_d[CAL_CYC_BIT] = cal_cyc_q;
				rd_d[CAL_RUN_BIT] = cal_run_q;
				rd_d[CAL_RDY_BIT] = cal_rdy_q;
				rd_d[CAL_TGT_LSB +: TGT_W] = tgt_q;
			end
			OFS_CAL_VALUE: rd_d = result_q;
			default: mapped = 1'b0;
		endcase
	end

	// one wait-free access phase: answer prepared during setup
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				prdata <= rd_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// config register

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en_q <= 1'b0;
			up_q <= 1'b1;
			reload_q <= 1'b0;
			div_q <= DIV_RST;
			xtal_q <= 1'b0;
		end else if (wr && paddr == OFS_CONFIG) begin
			en_q <= pwdata[CFG_EN_BIT];
			up_q <= pwdata[CFG_UP_BIT]; // RULE6
			reload_q <= pwdata[CFG_RELOAD_BIT];
			div_q <= pwdata[CFG_DIV_LSB +: DIV_W];
			xtal_q <= pwdata[CFG_XTAL_BIT]; // RULE1
		end
	end

	// software arming wins over a same-cycle alarm so a rearm is not lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			arm_q <= 1'b0;
		end else if (wr && paddr == OFS_CONFIG) begin
			arm_q <= pwdata[CFG_ARM_BIT];
		end else if (fire) begin
			arm_q <= 1'b0; // RULE14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// match, preset and snapshot registers

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			match_q <= '0;
			preset_q <= '0;
		end else if (wr) begin
			if (paddr == OFS_MATCH_LO) begin
				match_q[LO_W-1:0] <= pwdata; // RULE8
			end
			if (paddr == OFS_MATCH_HI) begin
				match_q[CNT_W-1:LO_W] <= pwdata[HI_W-1:0]; // RULE8
			end
			if (paddr == OFS_PRESET_LO) begin
				preset_q[LO_W-1:0] <= pwdata; // RULE16
			end
			if (paddr == OFS_PRESET_HI) begin
				preset_q[CNT_W-1:LO_W] <= pwdata[HI_W-1:0]; // RULE16
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			snap_q <= '0;
		end else if (wr && paddr == OFS_SNAP_TRIG) begin
			snap_q <= cnt_q; // RULE7
		end
	end

	////////////////////////////////////////////////////////////////////////
	// comparator
	// distance measured in the counting direction; zero means the count is at the match,
	// more than half the range means the match already lies behind the count

	assign diff = up_q ? (match_q - cnt_q) : (cnt_q - match_q); // RULE10 RULE12
	assign fire = arm_q && ((diff == '0) || (diff > HALF_RANGE)); // RULE9 RULE11 RULE13

	////////////////////////////////////////////////////////////////////////
	// time-base counter
	// a software reload outranks an alarm reload in the same cycle

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (wr && paddr == OFS_PRESET_TRIG) begin
			cnt_q <= preset_q; // RULE17 RULE18
		end else if (fire && reload_q) begin
			cnt_q <= preset_q; // RULE15 RULE19
		end else if (tick) begin
			// plain 54-bit arithmetic wraps both ways
			cnt_q <= up_q ? cnt_q + 54'h1 : cnt_q - 54'h1; // RULE5 RULE22
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ena_q <= 1'b0;
		end else if (wr && paddr == OFS_INT_ENA) begin
			ena_q <= pwdata[0];
		end
	end

	// a new alarm beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			raw_q <= 1'b0;
		end else if (fire) begin
			raw_q <= 1'b1; // RULE15 RULE24
		end else if (wr && paddr == OFS_INT_CLR && pwdata[0]) begin
			raw_q <= 1'b0; // RULE24
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= raw_q && ena_q; // RULE23
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slow clock measurement
	// no timeout: a stopped slow clock leaves the measurement running

	assign cal_start = wr && paddr == OFS_CAL_CFG && pwdata[CAL_START_BIT]; // RULE20
	assign cal_done = slow_rise && (scnt_q + 15'h0001 >= tgt_q);
	assign xcnt_next = xcnt_q + {31'h0000_0000, xtal_rise};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_cyc_q <= 1'b0;
			tgt_q <= TGT_RST;
		end else if (wr && paddr == OFS_CAL_CFG) begin
			cal_cyc_q <= pwdata[CAL_CYC_BIT]; // RULE20
			tgt_q <= pwdata[CAL_TGT_LSB +: TGT_W];
		end
	end

	// periodic mode restarts both counters on the cycle of completion
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_run_q <= 1'b0;
			cal_rdy_q <= 1'b0;
			scnt_q <= '0;
			xcnt_q <= '0;
			result_q <= '0;
		end else if (cal_start) begin
			cal_run_q <= 1'b1; // RULE21
			cal_rdy_q <= 1'b0;
			scnt_q <= '0;
			xcnt_q <= '0;
		end else if (cal_run_q) begin
			if (cal_done) begin
				result_q <= xcnt_next; // RULE21
				cal_rdy_q <= 1'b1;
				cal_run_q <= cal_cyc_q; // RULE20
				scnt_q <= '0;
				xcnt_q <= '0;
			end else begin
				scnt_q <= scnt_q + {14'h0000, slow_rise}; // RULE21
				xcnt_q <= xcnt_next; // RULE21
			end
		end
	end

endmodule : gpt_timer

/* File: include/gpt_pkg.sv */
/*
 * gpt_pkg: constants shared by the general purpose timer.
 * assumes a 32-bit apb register bus and a 20 MHz system clock.
 */
package gpt_pkg;
	// widths
	localparam int CNT_W = 54;
	localparam int LO_W = 32;
	localparam int HI_W = 22;
	localparam int DIV_W = 16;
	localparam int TGT_W = 15;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SNAP_LO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SNAP_HI = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SNAP_TRIG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MATCH_LO = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MATCH_HI = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PRESET_LO = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PRESET_HI = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_PRESET_TRIG = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_INT_ENA = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_INT_RAW = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_INT_ST = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_INT_CLR = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_CAL_CFG = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_CAL_VALUE = 8'h38;

	// config register fields
	localparam int CFG_EN_BIT = 31;
	localparam int CFG_UP_BIT = 30;
	localparam int CFG_RELOAD_BIT = 29;
	localparam int CFG_DIV_LSB = 13;
	localparam int CFG_ARM_BIT = 10;
	localparam int CFG_XTAL_BIT = 9;

	// calibration config fields
	localparam int CAL_START_BIT = 31;
	localparam int CAL_CYC_BIT = 30;
	localparam int CAL_RUN_BIT = 16;
	localparam int CAL_RDY_BIT = 15;
	localparam int CAL_TGT_LSB = 0;

	// reset values and magic numbers
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0001;
	localparam logic [TGT_W-1:0] TGT_RST = 15'h0100;
	localparam logic [CNT_W-1:0] HALF_RANGE = 54'h20_0000_0000_0000;
	localparam logic [DIV_W:0] DIV_ZERO_RATIO = 17'h1_0000;
	localparam logic [DIV_W:0] DIV_ONE_RATIO = 17'h0_0002;
endpackage : gpt_pkg

/* File: include/gpt_tick_if.sv */
/*
 * gpt_tick_if: carries the source pulse and divisor into the prescaler
 * and the tick back out. assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface gpt_tick_if;
	logic src_pulse;
	logic run;
	logic [15:0] divisor;
	logic tick;
	modport ctl (output src_pulse, output run, output divisor, input tick);
	modport pre (input src_pulse, input run, input divisor, output tick);
endinterface : gpt_tick_if

/* File: rtl/gpt_pin_sync.sv */
/*
 * gpt_pin_sync: three-stage synchroniser with rising edge pulse.
 * assumes the pin is slow against clk (several clk periods per level).
 */
`timescale 1ns/10ps
module gpt_pin_sync import gpt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pin side
	input wire logic pin,
	// clean side
	output logic rise
);
	logic s1_q, s2_q, s3_q, lvl_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a level counts only once stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lvl_q <= 1'b0;
			rise <= 1'b0;
		end else begin
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
			rise <= (s2_q == s3_q) && s3_q && !lvl_q;
		end
	end
endmodule : gpt_pin_sync

/* File: rtl/gpt_prescaler.sv */
/*
 * gpt_prescaler: divides source pulses into tick pulses.
 * assumes the divisor is only changed while run is low.
 */
`timescale 1ns/10ps
module gpt_prescaler import gpt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control and tick
	gpt_tick_if.pre tk
);
	logic [DIV_W:0] ratio;
	logic [DIV_W:0] cnt_q;

	always_comb begin
		if (tk.divisor == 16'h0000) begin
			ratio = DIV_ZERO_RATIO; // RULE3
		end else if (tk.divisor == 16'h0001) begin
			ratio = DIV_ONE_RATIO; // RULE3
		end else begin
			ratio = {1'b0, tk.divisor}; // RULE2
		end
	end

	// counter restarts whenever the timer is halted
	always_ff @(posedge clk) begin
		if (sys_rst || !tk.run) begin
			cnt_q <= '0;
			tk.tick <= 1'b0;
		end else if (tk.src_pulse) begin
			if (cnt_q >= ratio - 17'h0_0001) begin
				cnt_q <= '0;
				tk.tick <= 1'b1; // RULE2
			end else begin
				cnt_q <= cnt_q + 17'h0_0001;
				tk.tick <= 1'b0;
			end
		end else begin
			tk.tick <= 1'b0;
		end
	end
endmodule : gpt_prescaler

/* File: dv/gpt_timer_asserts.sv */
/* gpt_timer_asserts: concurrent checks on the timer's apb and interrupt ports.
   assumes one clk domain with synchronous active high reset; bound to gpt_timer. */
`timescale 1ns/10ps
module gpt_timer_asserts import gpt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic crystal_clock,
	input wire logic low_speed_clock,
	input wire logic timer_irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////
	logic acc, wr, rd, mapped, drop_ok;
	logic ena_q, snap_v_q, arm_gone_q;
	logic [DATA_W-1:0] snap_q;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_CAL_VALUE);
	assign drop_ok = wr && ((paddr == OFS_INT_CLR && pwdata[0]) || (paddr == OFS_INT_ENA && !pwdata[0]));
	// shadows of state the checker cannot see inside the block
	always_ff @(posedge clk) ena_q <= sys_rst ? 1'b0 :
		(wr && paddr == OFS_INT_ENA) ? pwdata[0] : ena_q;
	always_ff @(posedge clk) snap_v_q <= sys_rst ? 1'b0 : (wr && paddr == OFS_SNAP_TRIG) ? 1'b0 :
		(rd && paddr == OFS_SNAP_LO) ? 1'b1 : snap_v_q;
	always_ff @(posedge clk) snap_q <= (rd && paddr == OFS_SNAP_LO) ? prdata : snap_q;
	// a config write in flight may re-arm, so it forgets the alarm
	always_ff @(posedge clk) arm_gone_q <= sys_rst ? 1'b0 : (wr && paddr == OFS_CONFIG) ? 1'b0 :
		$rose(timer_irq) ? 1'b1 : arm_gone_q;
	////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_pulse;
		pready ##1 !pready;
	endsequence
	chk_apb_ready: assert property (s_setup |=> s_pulse)
		else $error("pready not one pulse after setup");
	chk_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	chk_err_data: assert property (rd && pslverr |-> prdata == '0)
		else $error("read data not zero on error");
	chk_irq_held: assert property ($fell(timer_irq) |-> $past(drop_ok, 2))
		else $error("interrupt dropped without clear");
	chk_irq_masked: assert property (timer_irq |-> $past(ena_q))
		else $error("interrupt high while disabled");
	chk_snap_hold: assert property (rd && paddr == OFS_SNAP_LO && snap_v_q |-> prdata == snap_q)
		else $error("snapshot changed without trigger");
	chk_arm_clear: assert property (rd && paddr == OFS_CONFIG && arm_gone_q |-> !prdata[CFG_ARM_BIT])
		else $error("arm bit still set after alarm");
	chk_hi_width: assert property (rd && (paddr == OFS_MATCH_HI || paddr == OFS_SNAP_HI) |->
		prdata[DATA_W-1:HI_W] == '0) else $error("high word wider than 22 bits");
endmodule : gpt_timer_asserts

bind gpt_timer gpt_timer_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .crystal_clock(crystal_clock), .low_speed_clock(low_speed_clock),
	.timer_irq(timer_irq));

/* File: dv/gpt_timer_tb.sv */
/* gpt_timer_tb: self-checking bench for gpt_timer over apb.
   assumes the checker is bound separately; crystal and slow pins are made here. */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	$display("unexpected %s exp %h got %h", nm, ex, got); fail_count++; end end
module gpt_timer_tb import gpt_pkg::*;;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic e;} gpt_row_s;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic crystal_clock = 0, low_speed_clock = 0, pready, pslverr, timer_irq, err;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat, s0;
	int fail_count = 0, checks = 0, cyc = 0, n;
	gpt_row_s rows[] = '{'{0, OFS_CONFIG, 32'h4000_2000, 0}, '{0, OFS_CAL_CFG, 32'h0000_0100, 0},
		'{0, 8'h40, 32'h0, 1}, '{1, OFS_MATCH_HI, 32'hFFFF_FFFF, 0},
		'{0, OFS_MATCH_HI, 32'h003F_FFFF, 0}, '{1, OFS_MATCH_LO, 32'h5, 0},
		'{1, OFS_MATCH_HI, 32'h0, 0}, '{1, OFS_PRESET_LO, 32'h10, 0},
		'{1, OFS_SNAP_TRIG, 32'h0, 0}, '{0, OFS_SNAP_LO, 32'h0, 0},
		'{1, OFS_PRESET_TRIG, 32'h0, 0}, '{1, OFS_SNAP_TRIG, 32'h0, 0},
		'{1, OFS_SNAP_LO, 32'h0, 0}, '{0, OFS_SNAP_LO, 32'h10, 0},
		'{1, OFS_INT_ENA, 32'h1, 0}, '{0, OFS_INT_RAW, 32'h0, 0},
		'{1, OFS_CONFIG, 32'h4000_2400, 0}, '{0, OFS_INT_RAW, 32'h1, 0},
		'{0, OFS_CONFIG, 32'h4000_2000, 0}, '{0, OFS_INT_ST, 32'h1, 0},
		'{1, OFS_INT_ENA, 32'h0, 0}, '{0, OFS_INT_ST, 32'h0, 0},
		'{1, OFS_INT_CLR, 32'h1, 0}, '{0, OFS_INT_RAW, 32'h0, 0},
		'{1, OFS_MATCH_LO, 32'h20, 0}, '{1, OFS_CONFIG, 32'h0000_2400, 0},
		'{0, OFS_INT_RAW, 32'h1, 0}, '{1, OFS_INT_CLR, 32'h1, 0},
		'{1, OFS_PRESET_LO, 32'h0, 0}, '{1, OFS_PRESET_TRIG, 32'h0, 0},
		'{1, OFS_CONFIG, 32'h8000_2000, 0}, '{1, OFS_CONFIG, 32'h0000_2000, 0},
		'{1, OFS_SNAP_TRIG, 32'h0, 0}, '{0, OFS_SNAP_HI, 32'h003F_FFFF, 0}};
	// up div 1, down div 3, div 0, crystal div 1; gaps are whole tick periods
	logic [31:0] cfg_t[4] = '{32'hC000_2000, 32'h8000_6000, 32'hC000_0000, 32'hC000_2200};
	logic [31:0] diff_t[4] = '{32'h32, 32'hFFFF_FFDF, 32'h1, 32'hA};
	int gap_t[4] = '{100, 99, 65536, 200};
	////////////////////////////////////////////////////////////
	gpt_timer uut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_clock(crystal_clock), .low_speed_clock(low_speed_clock), .timer_irq(timer_irq));
	always #25 clk = ~clk;
	// crystal at a tenth of clk, slow clock at an eightieth
	always @(posedge clk) begin
		cyc <= cyc + 1;
		crystal_clock <= (cyc % 10) < 5;
		low_speed_clock <= (cyc % 80) < 40;
		if (cyc == 90000) begin
			fail_count++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////
	task finish_test;
		if (fail_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	// one idle edge first so no signal is assigned twice in a time step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the bench timeout ends a wait for pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task snap_lo;
		apb(1'b1, OFS_SNAP_TRIG, 32'h0);
		apb(1'b0, OFS_SNAP_LO, 32'h0);
	endtask : snap_lo
	////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) `CHK("read data", rows[i].d, rdat)
			`CHK("slave error", rows[i].e, err)
		end
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFS_CONFIG, 32'h4000_2000);
			apb(1'b1, OFS_CONFIG, cfg_t[i]);
			snap_lo();
			s0 = rdat;
			repeat (gap_t[i] - 6) @(posedge clk);
			snap_lo();
			`CHK("count step", diff_t[i], rdat - s0)
			s0 = rdat;
			apb(1'b0, OFS_SNAP_LO, 32'h0);
			`CHK("snapshot held", s0, rdat)
		end
		// reverse while running: 3 or 4 ticks up, then 48 down
		apb(1'b1, OFS_CONFIG, 32'h4000_2000);
		apb(1'b1, OFS_CONFIG, 32'hC000_2000);
		snap_lo();
		s0 = rdat;
		apb(1'b1, OFS_CONFIG, 32'h8000_2000);
		repeat (94) @(posedge clk);
		snap_lo();
		`CHK("reversed step", 1'b1, $signed(rdat - s0) > -50 && $signed(rdat - s0) < -40)
		apb(1'b1, OFS_CONFIG, 32'h4000_2000);
		apb(1'b1, OFS_PRESET_LO, 32'h10);
		apb(1'b1, OFS_PRESET_TRIG, 32'h0);
		apb(1'b1, OFS_MATCH_LO, 32'h30);
		apb(1'b1, OFS_INT_ENA, 32'h1);
		apb(1'b1, OFS_CONFIG, 32'hE000_2400);
		n = 0;
		while (timer_irq !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		`CHK("alarm wait", 1'b1, n > 55 && n < 75)
		apb(1'b1, OFS_CONFIG, 32'h4000_2000);
		snap_lo();
		`CHK("reloaded count", 1'b1, rdat < 32'h18)
		`CHK("irq level", 1'b1, timer_irq)
		apb(1'b1, OFS_INT_CLR, 32'h1);
		apb(1'b1, OFS_PRESET_LO, 32'h50);
		apb(1'b1, OFS_PRESET_TRIG, 32'h0);
		apb(1'b1, OFS_CONFIG, 32'hA000_2400);
		n = 0;
		while (timer_irq !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		`CHK("down alarm wait", 1'b1, n > 55 && n < 75)
		apb(1'b1, OFS_CONFIG, 32'h4000_2000);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, OFS_CAL_CFG, m ? 32'hC000_0004 : 32'h8000_0004);
			do apb(1'b0, OFS_CAL_CFG, 32'h0);
			while (rdat[CAL_RDY_BIT] !== 1'b1);
			apb(1'b0, OFS_CAL_VALUE, 32'h0);
			`CHK("crystal count", 1'b1, rdat >= 24 && rdat <= 40)
		end
		// reset in mid-run while the interrupt is still pending
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, OFS_INT_RAW, 32'h0);
		`CHK("raw after reset", 32'h0, rdat)
		`CHK("irq after reset", 1'b0, timer_irq)
		finish_test();
	end
endmodule : gpt_timer_tb
